// ===== verilog/dcff_flags.sv
// fifo with status flags, offset registers and reset-time configuration
//
// Function
// [RL1] fall-through: output ready low after first write
// [RL2] fall-through: almost empty high at n+2 words
// [RL3] fall-through: half full low at depth/2+2
// [RL4] fall-through: almost full low at depth+1-m
// [RL5] fall-through: input ready high at depth+1, block
// [RL6] first read from full releases input ready
// [RL7] fall-through: almost empty low at n+1
// [RL8] empty: output ready high, reads ignored
// [RL9] load and write low: load offsets alternately
// [RL10] load high resumes; offset sequence position kept
// [RL11] load and read low: read offsets alternately
// [RL12] offset readback only in standard mode
// [RL13] async partial flags follow count at once; half full is always registered
// [RL14] sync partial flags update on clock only
// [RL15] stages only on boundary flags, listed combinations
// [RL16] each stage adds one cycle of flag latency
// [RL17] empty offset default by depth
// [RL18] full offset default by depth
// [RL19] standard mode: full after depth writes
// [RL20] straps sampled in reset select timing mode
// [RL21] reset loads default offsets, restarts sequence
// [RL22] load and read sequence pointers independent
`timescale 1ns/100ps
module dcff_flags #(
  parameter int DEPTH = dcff_pkg::DEPTH_DEF,
  parameter int WIDTH = dcff_pkg::DATA_W
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                first_load_sel,
  input  wire logic                read_expand_in,
  input  wire logic                write_expand_in,
  input  wire logic                write_en_n,
  input  wire logic [WIDTH-1:0]    data_in,
  input  wire logic                offset_load_n,
  input  wire logic                read_en_n,
  output logic [WIDTH-1:0]         data_out,
  output dcff_pkg::dcff_flags_s    flags
);

  localparam int OW = dcff_pkg::OFS_W;
  localparam int CW = dcff_pkg::CMP_W;
  localparam int SW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_C  = CW'(DEPTH / 2);

  // ****************************************
  // decoding functions
  // ****************************************
  function automatic dcff_pkg::dcff_cfg_s cfg_decode(
    input logic [2:0] s
  );
    dcff_pkg::dcff_cfg_s c;
    logic                fl;
    logic                rx;
    logic                wx;
    fl = s[dcff_pkg::STRAP_FL];
    rx = s[dcff_pkg::STRAP_RXI];
    wx = s[dcff_pkg::STRAP_WXI];
    c.fall_through_mode = !rx && wx; // RL20
    c.sync_partial      = fl && !(rx && wx);
    if (!rx && wx) begin // RL15
      c.empty_stages = dcff_pkg::STG_TRIPLE;
      c.full_stages  = dcff_pkg::STG_DOUBLE;
    end else if (rx && !wx) begin
      c.empty_stages = dcff_pkg::STG_DOUBLE;
      c.full_stages  = dcff_pkg::STG_DOUBLE;
    end else begin
      c.empty_stages = dcff_pkg::STG_SINGLE;
      c.full_stages  = dcff_pkg::STG_SINGLE;
    end
    return c;
  endfunction

  function automatic logic [OW-1:0] ofs_default(input int d);
    if (d == dcff_pkg::DEPTH_DEF) begin
      return dcff_pkg::OFS_DEF_SMALL;
    end else if (d == dcff_pkg::DEPTH_MID) begin
      return dcff_pkg::OFS_DEF_MID;
    end
    return dcff_pkg::OFS_DEF_LARGE;
  endfunction

  localparam logic [OW-1:0] EMPTY_DEF = ofs_default(DEPTH); // RL17
  localparam logic [OW-1:0] FULL_DEF  = ofs_default(DEPTH); // RL18

  // ****************************************
  // strap synchroniser and configuration
  // ****************************************
  logic [2:0]          strap_s1_reg;
  logic [2:0]          strap_s2_reg;
  dcff_pkg::dcff_cfg_s cfg_reg;
  dcff_pkg::dcff_cfg_s cfg_next;

  // captured on every edge while reset is low, then frozen
  always_comb begin
    cfg_next = cfg_reg;
    if (!rst_n) begin
      cfg_next = cfg_decode(strap_s2_reg); // RL20
    end
  end

  always_ff @(posedge clk_sys) begin
    strap_s1_reg <= {first_load_sel, read_expand_in, write_expand_in};
    strap_s2_reg <= strap_s1_reg;
    if (!rst_n || ce) begin
      cfg_reg <= cfg_next;
    end
  end

  // ****************************************
  // storage array
  // ****************************************
  logic             st_in_valid;
  logic             st_in_ready;
  logic             st_out_valid;
  logic             st_out_ready;
  logic [WIDTH-1:0] st_out_data;
  logic [SW-1:0]    st_count;

  dcff_store #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_store (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_valid  (st_in_valid),
    .in_ready  (st_in_ready),
    .in_data   (data_in),
    .out_valid (st_out_valid),
    .out_ready (st_out_ready),
    .out_data  (st_out_data),
    .count     (st_count)
  );

  // ****************************************
  // read/write control and offset registers
  // ****************************************
  logic             ld;
  logic             wr_req;
  logic             rd_req;
  logic             ofs_wr;
  logic             ofs_rd;
  logic             ft;
  logic             load_out;
  logic             std_pop;
  logic             out_valid_reg;
  logic             out_valid_next;
  logic [WIDTH-1:0] dout_reg;
  logic [WIDTH-1:0] dout_next;
  logic [OW-1:0]    empty_threshold_reg;
  logic [OW-1:0]    empty_threshold_next;
  logic [OW-1:0]    full_threshold_reg;
  logic [OW-1:0]    full_threshold_next;
  logic             ld_wr_sel_reg;
  logic             ld_wr_sel_next;
  logic             ld_rd_sel_reg;
  logic             ld_rd_sel_next;

  assign ld     = !offset_load_n;
  assign wr_req = !write_en_n;
  assign rd_req = !read_en_n;
  assign ft     = cfg_reg.fall_through_mode;
  assign ofs_wr = ld && wr_req; // RL9
  assign ofs_rd = ld && rd_req && !ft; // RL12

  // writes during offset loading never reach the array
  assign st_in_valid = wr_req && !ld; // RL5 RL19
  // empty array: read request has no effect
  assign std_pop  = !ft && rd_req && !ld; // RL8
  // output register refills from the array without a read
  assign load_out = ft && st_out_valid
                    && (!out_valid_reg || (rd_req && !ld)); // RL1
  assign st_out_ready = ft ? load_out : std_pop;
  assign data_out     = dout_reg;

  always_comb begin
    out_valid_next       = out_valid_reg;
    dout_next            = dout_reg;
    empty_threshold_next = empty_threshold_reg;
    full_threshold_next  = full_threshold_reg;
    ld_wr_sel_next       = ld_wr_sel_reg;
    ld_rd_sel_next       = ld_rd_sel_reg;
    if (load_out) begin // RL1
      out_valid_next = 1'b1;
      dout_next      = st_out_data;
    end else if (ft && rd_req && !ld) begin
      out_valid_next = 1'b0; // RL8
    end
    if (std_pop && st_out_valid) begin
      dout_next = st_out_data;
    end
    if (ofs_wr) begin // RL9 RL10
      if (ld_wr_sel_reg) begin
        full_threshold_next = data_in[OW-1:0];
      end else begin
        empty_threshold_next = data_in[OW-1:0];
      end
      ld_wr_sel_next = !ld_wr_sel_reg;
    end
    if (ofs_rd) begin // RL11 RL22
      dout_next      = WIDTH'(ld_rd_sel_reg ? full_threshold_reg
                                            : empty_threshold_reg);
      ld_rd_sel_next = !ld_rd_sel_reg;
    end
    if (!rst_n) begin // RL21
      out_valid_next       = 1'b0;
      dout_next            = dcff_pkg::DOUT_RST;
      empty_threshold_next = EMPTY_DEF; // RL17
      full_threshold_next  = FULL_DEF; // RL18
      ld_wr_sel_next       = 1'b0; // RL22
      ld_rd_sel_next       = 1'b0; // RL22
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || ce) begin
      out_valid_reg       <= out_valid_next;
      dout_reg            <= dout_next;
      empty_threshold_reg <= empty_threshold_next;
      full_threshold_reg  <= full_threshold_next;
      ld_wr_sel_reg       <= ld_wr_sel_next;
      ld_rd_sel_reg       <= ld_rd_sel_next;
    end
  end

  // ****************************************
  // word count and flag thresholds
  // ****************************************
  logic [CW-1:0] cnt;
  logic [CW-1:0] ae_lim;
  logic [CW-1:0] hf_lim;
  logic [CW-1:0] af_lim;
  logic          ae_low;
  logic          af_low;
  logic          hf_low;
  logic          empty_ind;
  logic          full_ind;

  // output register counts as capacity in fall-through mode
  assign cnt = CW'(st_count) + ((ft && out_valid_reg) ? dcff_pkg::FT_EXTRA
                                                       : '0);
  assign ae_lim = CW'(empty_threshold_reg)
                  + (ft ? dcff_pkg::FT_EXTRA : '0); // RL2 RL7
  assign hf_lim = HALF_C + (ft ? dcff_pkg::HF_FT_ADD
                               : dcff_pkg::HF_STD_ADD); // RL3
  // offset beyond capacity wraps high, so the flag never asserts
  assign af_lim = DEPTH_C + (ft ? dcff_pkg::FT_EXTRA : '0)
                  - CW'(full_threshold_reg); // RL4
  assign ae_low = (cnt <= ae_lim); // RL2 RL7
  assign hf_low = (cnt >= hf_lim); // RL3 RL6
  assign af_low = (cnt >= af_lim); // RL4 RL6
  assign empty_ind = ft ? !out_valid_reg : (st_count == '0); // RL8
  assign full_ind  = ft ? (cnt == DEPTH_C + dcff_pkg::FT_EXTRA)
                        : (cnt == DEPTH_C); // RL5 RL19

  // ****************************************
  // flag stages and partial flag timing
  // ****************************************
  logic [2:0] empty_pipe_reg;
  logic [2:0] empty_pipe_next;
  logic [2:0] full_pipe_reg;
  logic [2:0] full_pipe_next;
  logic       ae_sync_reg;
  logic       ae_sync_next;
  logic       af_sync_reg;
  logic       af_sync_next;
  logic       hf_sync_reg;
  logic       hf_sync_next;
  logic       empty_out;
  logic       full_out;

  // extra stages trade latency for a settled boundary flag
  always_comb begin
    empty_pipe_next = {empty_pipe_reg[1:0], empty_ind}; // RL16
    full_pipe_next  = {full_pipe_reg[1:0], full_ind}; // RL16
    ae_sync_next    = !ae_low; // RL14
    af_sync_next    = !af_low; // RL14
    hf_sync_next    = !hf_low;
    if (!rst_n) begin
      empty_pipe_next = 3'h7;
      full_pipe_next  = 3'h0;
      ae_sync_next    = 1'b0;
      af_sync_next    = 1'b1;
      hf_sync_next    = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || ce) begin
      empty_pipe_reg <= empty_pipe_next;
      full_pipe_reg  <= full_pipe_next;
      ae_sync_reg    <= ae_sync_next;
      af_sync_reg    <= af_sync_next;
      hf_sync_reg    <= hf_sync_next;
    end
  end

  assign empty_out = empty_pipe_reg[cfg_reg.empty_stages - 2'h1]; // RL15
  assign full_out  = full_pipe_reg[cfg_reg.full_stages - 2'h1]; // RL15

  // polarity of the boundary flags turns over in fall-through mode
  assign flags.empty_flag_n   = ft ? empty_out : !empty_out; // RL1 RL8
  assign flags.full_flag_n    = ft ? full_out : !full_out; // RL5 RL6
  assign flags.almost_empty_n = cfg_reg.sync_partial ? ae_sync_reg
                                                     : !ae_low; // RL13
  assign flags.almost_full_n  = cfg_reg.sync_partial ? af_sync_reg
                                                     : !af_low; // RL13
  assign flags.half_full_n    = hf_sync_reg;

endmodule // dcff_flags

// ===== verilog/dcff_pkg.sv
// package: constants, configuration and flag types of the fifo flag block
package dcff_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int DATA_W    = 18;
  localparam int OFS_W     = 12;
  localparam int DEPTH_DEF = 256;
  localparam int DEPTH_MID = 512;
  localparam int CMP_W     = 14;
  localparam int BUF_DEPTH = 8;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [OFS_W-1:0]  OFS_DEF_SMALL = 12'h01f;
  localparam logic [OFS_W-1:0]  OFS_DEF_MID   = 12'h03f;
  localparam logic [OFS_W-1:0]  OFS_DEF_LARGE = 12'h07f;
  localparam logic [DATA_W-1:0] DOUT_RST      = 18'h00000;

  // ****************************************
  // flag stage counts and count offsets
  // ****************************************
  localparam logic [1:0]       STG_SINGLE = 2'h1;
  localparam logic [1:0]       STG_DOUBLE = 2'h2;
  localparam logic [1:0]       STG_TRIPLE = 2'h3;
  localparam logic [CMP_W-1:0] FT_EXTRA   = 14'h0001;
  localparam logic [CMP_W-1:0] HF_STD_ADD = 14'h0001;
  localparam logic [CMP_W-1:0] HF_FT_ADD  = 14'h0002;

  // strap fields: {first_load_sel, read_expand_in, write_expand_in}
  localparam int STRAP_FL  = 2;
  localparam int STRAP_RXI = 1;
  localparam int STRAP_WXI = 0;

  typedef struct packed {
    logic       fall_through_mode;
    logic       sync_partial;
    logic [1:0] empty_stages;
    logic [1:0] full_stages;
  } dcff_cfg_s;

  // empty_flag_n is output ready (low = data) in fall-through mode,
  // full_flag_n is input_ready_n (high = full) in fall-through mode
  typedef struct packed {
    logic empty_flag_n;
    logic full_flag_n;
    logic almost_empty_n;
    logic almost_full_n;
    logic half_full_n;
  } dcff_flags_s;

endpackage

// ===== verilog/dcff_store.sv
// storage fifo: flip-flop array with valid/ready on both sides
`timescale 1ns/100ps
module dcff_store #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8,
  localparam int AW   = $clog2(DEPTH),
  localparam int CW   = $clog2(DEPTH + 1)
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [CW-1:0]         count
);

  // ****************************************
  // storage and pointers
  // ****************************************
  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW-1:0]    rd_ptr_next;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign count     = count_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // depth must be a power of two: pointers wrap by overflow
  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next          = wr_ptr_reg + AW'(1);
    end
    if (pop) begin
      rd_ptr_next = rd_ptr_reg + AW'(1);
    end
    if (push && !pop) begin
      count_next = count_reg + CW'(1);
    end else if (pop && !push) begin
      count_next = count_reg - CW'(1);
    end
    if (!rst_n) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      count_next  = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || ce) begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // array left out of reset: contents unreadable until written
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      mem_reg <= mem_next;
    end
  end

endmodule // dcff_store

// ===== testbench/dcff_reader.sv
// reader model: pops at full rate or every other cycle on request
`timescale 1ns/100ps
module dcff_reader (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic req,
  input  wire logic slow,
  output logic      read_en_n
);
  // ****
  // phase
  // ****
  logic ph_reg;
  logic ph_next;
  always_comb begin
    ph_next = rst_n ? !ph_reg : 1'b0;
  end
  always_ff @(posedge clk_sys) begin
    ph_reg <= ph_next;
  end
  // slow mode stalls every other cycle, like a busy consumer
  assign read_en_n = !(req && (!slow || ph_reg));
endmodule // dcff_reader

// ===== testbench/dcff_flags_checker.sv
// checker: flag and output relations of the fifo flag block
`timescale 1ns/100ps
module dcff_flags_checker #(
  parameter int WIDTH = dcff_pkg::DATA_W
) (
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  read_expand_in,
  input wire logic                  write_expand_in,
  input wire logic                  write_en_n,
  input wire logic                  offset_load_n,
  input wire logic                  read_en_n,
  input wire logic [WIDTH-1:0]      data_out,
  input wire dcff_pkg::dcff_flags_s flags
);
  // ****
  // mode
  // ****
  logic ft;
  // straps only change with reset low, so the live level names the mode
  assign ft = !read_expand_in && write_expand_in;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ****
  // assertions
  // ****
  a_reset_flags: assert property ($rose(rst_n) |->
    flags.empty_flag_n == ft && flags.full_flag_n == !ft
    && !flags.almost_empty_n && flags.almost_full_n && flags.half_full_n
    && data_out == dcff_pkg::DOUT_RST)
    else $error("flags or data wrong after reset");
  a_std_dout_hold: assert property (
    !ft && read_en_n |=> $stable(data_out))
    else $error("standard output moved without read");
  a_std_empty_ignore: assert property (write_en_n[*4] ##0
    (!ft && !flags.empty_flag_n && !read_en_n && offset_load_n)
    |=> $stable(data_out)) else $error("read on empty changed output");
  a_ft_rb_blocked: assert property (write_en_n[*4] ##0
    (ft && !offset_load_n && !read_en_n) |=> $stable(data_out))
    else $error("offset readback acted in fall-through mode");
  a_ft_full_hold: assert property (read_en_n[*4] ##0
    (ft && flags.full_flag_n) |=> flags.full_flag_n)
    else $error("input ready dropped without read");
  a_std_full_hold: assert property (read_en_n[*4] ##0
    (!ft && !flags.full_flag_n) |=> !flags.full_flag_n)
    else $error("full flag released without read");
  // a write reaches output ready four edges later: window must cover it
  a_ft_empty_hold: assert property (write_en_n[*6] ##0
    (ft && flags.empty_flag_n) |=> flags.empty_flag_n)
    else $error("output ready without write");
  a_partial_idle: assert property ((write_en_n && read_en_n)[*2]
    |=> $stable({flags.almost_empty_n, flags.almost_full_n,
    flags.half_full_n})) else $error("partial flag moved while idle");
  c_ft_full: cover property (ft && flags.full_flag_n);
  c_std_full: cover property (!ft && !flags.full_flag_n);
  c_std_rb: cover property (!ft && !offset_load_n && !read_en_n);
endmodule // dcff_flags_checker
bind dcff_flags dcff_flags_checker #(.WIDTH(WIDTH)) chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .read_expand_in(read_expand_in),
  .write_expand_in(write_expand_in), .write_en_n(write_en_n),
  .offset_load_n(offset_load_n), .read_en_n(read_en_n),
  .data_out(data_out), .flags(flags));

// ===== testbench/dcff_flags_tb.sv
// testbench: fifo flags, offsets and timing modes
`timescale 1ns/100ps
module dcff_flags_tb;
  localparam int D  = 16;
  localparam int NO = 3;
  localparam int MO = 2;
  logic                  clk_sys = 1'b0;
  logic                  rst_n = 1'b0;
  logic [2:0]            strap = 3'h0;
  logic                  write_en_n = 1'b1;
  logic [17:0]           data_in = 18'h00000;
  logic                  offset_load_n = 1'b1;
  logic                  req = 1'b0;
  logic                  slow = 1'b0;
  logic                  read_en_n;
  logic [17:0]           data_out;
  dcff_pkg::dcff_flags_s flags;
  logic [2:0]            stds [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
  int                    err_count = 0;
  int                    check_count = 0;
  int                    cyc = 0;
  always #5 clk_sys = ~clk_sys;
  // ****
  // design and reader
  // ****
  dcff_flags #(.DEPTH(D)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
    .first_load_sel(strap[2]), .read_expand_in(strap[1]),
    .write_expand_in(strap[0]), .write_en_n(write_en_n),
    .data_in(data_in), .offset_load_n(offset_load_n),
    .read_en_n(read_en_n), .data_out(data_out), .flags(flags));
  dcff_reader rdr (.clk_sys(clk_sys), .rst_n(rst_n), .req(req),
    .slow(slow), .read_en_n(read_en_n));
  // ****
  // helpers
  // ****
  task automatic close_out;
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    // runs take about 2000 cycles
    if (cyc == 10000) begin
      err_count++;
      close_out;
    end
  end
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic settle;
    repeat (6) tick;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [17:0] ef(input logic ft, input int c);
    dcff_pkg::dcff_flags_s f;
    f.empty_flag_n   = ft ? (c == 0) : (c != 0);
    f.full_flag_n    = ft ? (c > D) : (c < D);
    f.almost_empty_n = c >= NO + 1 + int'(ft);
    f.almost_full_n  = c < D - MO + int'(ft);
    f.half_full_n    = c < D / 2 + 1 + int'(ft);
    return {13'h0000, f};
  endfunction
  function automatic logic [17:0] wd(input int j);
    return 18'h2a000 + 18'(j);
  endfunction
  task automatic do_reset(input logic [2:0] s);
    rst_n = 1'b0;
    strap = s;
    repeat (4) tick;
    rst_n = 1'b1;
    tick;
  endtask
  task automatic wr(input logic [17:0] d);
    write_en_n = 1'b0;
    data_in = d;
    tick;
    write_en_n = 1'b1;
  endtask
  task automatic rd;
    req = 1'b1;
    tick;
    req = 1'b0;
  endtask
  task automatic ld2(input logic [11:0] a, input logic [11:0] b,
                     input logic two);
    offset_load_n = 1'b0;
    write_en_n = 1'b0;
    data_in = {6'h00, a};
    tick;
    data_in = {6'h00, b};
    if (two) tick;
    write_en_n = 1'b1;
    offset_load_n = 1'b1;
    tick;
  endtask
  task automatic rb2(input logic [11:0] e1, input logic [11:0] e2);
    offset_load_n = 1'b0;
    req = 1'b1;
    tick;
    chk(data_out, {6'h00, e1});
    tick;
    chk(data_out, {6'h00, e2});
    req = 1'b0;
    offset_load_n = 1'b1;
    tick;
  endtask
  // ****
  // scenarios
  // ****
  task automatic sc_offsets;
    do_reset(3'h0);
    chk({13'h0000, flags}, ef(1'b0, 0));
    rb2(12'h07f, 12'h07f);
    ld2(12'h007, 12'h002, 1'b1);
    ld2(12'h003, 12'h000, 1'b0);
    rb2(12'h003, 12'h002);
    ld2(12'h005, 12'h000, 1'b0);
    rb2(12'h003, 12'h005);
    do_reset(3'h0);
    rb2(12'h07f, 12'h07f);
  endtask
  task automatic sc_run(input logic [2:0] s, input logic ft);
    int cap;
    int lat;
    cap = ft ? D + 1 : D;
    // edges from write to boundary flag: stages plus output load
    lat = ft ? 4 : ((s[1] && !s[0]) ? 2 : 1);
    do_reset(s);
    chk({13'h0000, flags}, ef(ft, 0));
    ld2(12'h003, 12'h002, 1'b1);
    for (int k = 1; k <= cap + 1; k++) begin
      wr(wd(k));
      if (k == 1) begin
        repeat (lat - 1) tick;
        chk(18'(flags.empty_flag_n), 18'(ft));
        tick;
        chk(18'(flags.empty_flag_n), 18'(!ft));
      end
      settle;
      chk({13'h0000, flags}, ef(ft, k > cap ? cap : k));
    end
    if (ft) begin
      offset_load_n = 1'b0;
      req = 1'b1;
      tick;
      req = 1'b0;
      offset_load_n = 1'b1;
      settle;
      chk(data_out, wd(1));
      chk({13'h0000, flags}, ef(ft, cap));
    end
    for (int j = 1; j <= cap; j++) begin
      if (ft) chk(data_out, wd(j));
      rd;
      settle;
      if (!ft) chk(data_out, wd(j));
      chk({13'h0000, flags}, ef(ft, cap - j));
    end
    rd;
    settle;
    chk(data_out, wd(cap));
    chk({13'h0000, flags}, ef(ft, 0));
  endtask
  task automatic sc_burst;
    do_reset(3'h1);
    ld2(12'h003, 12'h002, 1'b1);
    write_en_n = 1'b0;
    for (int k = 1; k <= 6; k++) begin
      data_in = wd(k);
      tick;
    end
    write_en_n = 1'b1;
    slow = 1'b1;
    req = 1'b1;
    // half rate: eight edges give four reads
    repeat (8) tick;
    req = 1'b0;
    slow = 1'b0;
    settle;
    chk(data_out, wd(5));
    chk({13'h0000, flags}, ef(1'b1, 2));
  endtask
  initial begin
    sc_offsets;
    for (int i = 0; i < 5; i++) sc_run(stds[i], 1'b0);
    sc_run(3'h1, 1'b1);
    sc_run(3'h5, 1'b1);
    sc_burst;
    close_out;
  end
endmodule // dcff_flags_tb
